// ==== rtl/ppp_pkg.sv ====
package ppp_pkg;
	// Action select encodings
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// Command bytes
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;
	// Memory geometry
	localparam int FLASH_AW = 12;
	localparam int EE_AW = 9;
	localparam int WORD_BITS = 7;
	localparam int EE_WORD_BITS = 3;
	// Reset values of nonvolatile bytes
	localparam logic [7:0] FUSE_LO_RST = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] LOCK_RST = 8'hFF;
	// Signature and calibration bytes, values arbitrary
	localparam logic [7:0] SIG0 = 8'h5A;
	localparam logic [7:0] SIG1 = 8'hA5;
	localparam logic [7:0] SIG2 = 8'h3C;
	localparam logic [7:0] CAL_BYTE = 8'h80;
	// Programming time, in microseconds, and its cycle count at 40 MHz
	localparam int PROG_TIME_US = 10;
	localparam int CLK_MHZ = 40;
	localparam logic [15:0] PROG_CYCLES = 16'(PROG_TIME_US * CLK_MHZ);
	// Lock bit positions
	localparam int LOCK_ONE_POS = 0;
	localparam int LOCK_TWO_POS = 1;
	localparam int BOOT_LOCK_LO = 2;
	localparam int BOOT_LOCK_HI = 5;
	// Host sequencing
	localparam logic [3:0] SETUP_CYCLES = 4'h3;
	localparam logic [7:0] NOP_RD = 8'h00;
endpackage : ppp_pkg

// ==== rtl/ppp_if.sv ====
`timescale 1ns/1ps
interface ppp_if;
	logic action_select_hi;
	logic action_select_lo;
	logic byte_select_1;
	logic byte_select_2;
	logic page_load_strobe;
	logic load_strobe_pin;
	logic write_strobe_n;
	logic output_enable_n;
	logic ready_busy;
	logic [7:0] data_host_out;
	logic data_host_oe;
	logic [7:0] data_dev_out;
	logic data_dev_oe;
	// Resolved bus level seen by both ends
	wire [7:0] data_bus = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hFF);
	modport dev (input action_select_hi, action_select_lo, byte_select_1, byte_select_2, page_load_strobe,
		load_strobe_pin, write_strobe_n, output_enable_n, data_bus, output ready_busy, data_dev_out, data_dev_oe);
	modport host (output action_select_hi, action_select_lo, byte_select_1, byte_select_2, page_load_strobe,
		load_strobe_pin, write_strobe_n, output_enable_n, data_host_out, data_host_oe, input ready_busy, data_bus);
endinterface : ppp_if

// ==== rtl/ppp_device.sv ====
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module ppp_device (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	ppp_if.dev port // Programming pins
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [7:0] raw;
	assign raw = {port.action_select_hi, port.action_select_lo, port.byte_select_1, port.byte_select_2,
		port.page_load_strobe, port.load_strobe_pin, port.write_strobe_n, port.output_enable_n};
	logic [7:0] ctl1_ff;
	logic [7:0] ctl2_ff;
	logic [7:0] dat1_ff;
	logic [7:0] dat2_ff;
	logic xtal_d_ff;
	logic pg_d_ff;
	logic wr_d_ff;
	// Two flops on every incoming pin; control flops reset to the idle pin levels so no false edge follows reset, data flops to 00
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctl1_ff <= 8'hC3;
			ctl2_ff <= 8'hC3;
			dat1_ff <= 8'h00;
			dat2_ff <= 8'h00;
		end else begin
			ctl1_ff <= raw;
			ctl2_ff <= ctl1_ff;
			dat1_ff <= port.data_bus;
			dat2_ff <= dat1_ff;
		end
	end
	wire [1:0] act = ctl2_ff[7:6];
	wire sel1 = ctl2_ff[5];
	wire sel2 = ctl2_ff[4];
	wire pg = ctl2_ff[3];
	wire xtal = ctl2_ff[2];
	wire wr_n = ctl2_ff[1];
	wire oe_n = ctl2_ff[0];
	wire [7:0] din = dat2_ff;
	// Edge detectors on synchronised strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			xtal_d_ff <= 1'b0;
			pg_d_ff <= 1'b0;
			wr_d_ff <= 1'b1;
		end else begin
			xtal_d_ff <= xtal;
			pg_d_ff <= pg;
			wr_d_ff <= wr_n;
		end
	end
	wire load_p = xtal & ~xtal_d_ff;
	wire pg_p = pg & ~pg_d_ff;
	wire wr_p = ~wr_n & wr_d_ff;
	////////////////////////////////////////////////////////////////////////////
	// Command, address and data latches
	logic [7:0] cmd_ff;
	logic [7:0] addr_lo_ff;
	logic [7:0] addr_hi_ff;
	logic [7:0] data_lo_ff;
	logic [7:0] data_hi_ff;
	logic busy_ff;
	logic [15:0] cnt_ff;
	wire ld_addr = load_p && act == ppp_pkg::ACT_ADDR && !busy_ff;
	wire ld_data = load_p && act == ppp_pkg::ACT_DATA && !busy_ff;
	wire ld_cmd = load_p && act == ppp_pkg::ACT_CMD && !busy_ff;
	// Byte loads; a no-op command clears write controls
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= ppp_pkg::CMD_NOP;
			addr_lo_ff <= 8'h00;
			addr_hi_ff <= 8'h00;
			data_lo_ff <= 8'h00;
			data_hi_ff <= 8'h00;
		end else begin
			if (ld_cmd)
				cmd_ff <= din;
			if (ld_addr && sel1)
				addr_hi_ff <= din;
			if (ld_addr && !sel1)
				addr_lo_ff <= din;
			if (ld_data && sel1)
				data_hi_ff <= din;
			if (ld_data && !sel1)
				data_lo_ff <= din;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Memories and page buffers
	logic [15:0] flash_mem [0:(1<<ppp_pkg::FLASH_AW)-1];
	logic [7:0] ee_mem [0:(1<<ppp_pkg::EE_AW)-1];
	logic [15:0] fpage_buf [0:(1<<ppp_pkg::WORD_BITS)-1];
	logic [7:0] epage_buf [0:(1<<ppp_pkg::EE_WORD_BITS)-1];
	logic [7:0] fuse_lo_ff;
	logic [7:0] fuse_hi_ff;
	logic [7:0] fuse_ext_ff;
	logic [7:0] lock_ff;
	wire [15:0] addr = {addr_hi_ff, addr_lo_ff};
	// Word within page from low bits, page from upper bits
	wire [ppp_pkg::WORD_BITS-1:0] fword = addr[ppp_pkg::WORD_BITS-1:0];
	wire [ppp_pkg::FLASH_AW-1:ppp_pkg::WORD_BITS] fpage = addr[ppp_pkg::FLASH_AW-1:ppp_pkg::WORD_BITS];
	wire [ppp_pkg::EE_WORD_BITS-1:0] eword = addr[ppp_pkg::EE_WORD_BITS-1:0];
	wire [ppp_pkg::EE_AW-1:ppp_pkg::EE_WORD_BITS] epage = addr[ppp_pkg::EE_AW-1:ppp_pkg::EE_WORD_BITS];
	wire is_ee = cmd_ff == ppp_pkg::CMD_WR_EE;
	// Page strobe latches the loaded word, with select high for flash and any select for EEPROM
	always_ff @(posedge clock) begin
		if (pg_p && sel1 && cmd_ff == ppp_pkg::CMD_WR_FLASH)
			fpage_buf[fword] <= {data_hi_ff, data_lo_ff};
		if (pg_p && is_ee)
			epage_buf[eword] <= data_lo_ff;
	end
	wire start = wr_p && !busy_ff;
	wire boot_locked = !lock_ff[ppp_pkg::LOCK_ONE_POS] && !lock_ff[ppp_pkg::LOCK_TWO_POS];
	always_ff @(posedge clock) begin
		if (start && cmd_ff == ppp_pkg::CMD_WR_FLASH)
			for (int i = 0; i < (1 << ppp_pkg::WORD_BITS); i++)
				flash_mem[{fpage, 7'(i)}] <= fpage_buf[i];
		if (start && is_ee && !sel1)
			for (int i = 0; i < (1 << ppp_pkg::EE_WORD_BITS); i++)
				ee_mem[{epage, 3'(i)}] <= epage_buf[i];
		if (start && cmd_ff == ppp_pkg::CMD_ERASE) begin
			for (int i = 0; i < (1 << ppp_pkg::FLASH_AW); i++)
				flash_mem[i] <= 16'hFFFF;
			for (int i = 0; i < (1 << ppp_pkg::EE_AW); i++)
				ee_mem[i] <= 8'hFF;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fuse_lo_ff <= ppp_pkg::FUSE_LO_RST;
			fuse_hi_ff <= ppp_pkg::FUSE_HI_RST;
			fuse_ext_ff <= ppp_pkg::FUSE_EXT_RST;
			lock_ff <= ppp_pkg::LOCK_RST;
		end else if (start) begin
			if (cmd_ff == ppp_pkg::CMD_WR_FUSE) begin
				if (!sel1 && !sel2)
					fuse_lo_ff <= data_lo_ff;
				if (sel1 && !sel2)
					fuse_hi_ff <= data_lo_ff;
				if (!sel1 && sel2)
					fuse_ext_ff <= data_lo_ff;
			end
			// Lock write only ever clears bits; boot bits frozen in mode three
			if (cmd_ff == ppp_pkg::CMD_WR_LOCK) begin
				lock_ff[1:0] <= lock_ff[1:0] & data_lo_ff[1:0];
				lock_ff[7:6] <= lock_ff[7:6] & data_lo_ff[7:6];
				if (!boot_locked)
					lock_ff[5:2] <= lock_ff[5:2] & data_lo_ff[5:2];
			end
			if (cmd_ff == ppp_pkg::CMD_ERASE)
				lock_ff <= ppp_pkg::LOCK_RST;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Busy timer
	wire is_write = cmd_ff == ppp_pkg::CMD_WR_FLASH || is_ee || cmd_ff == ppp_pkg::CMD_WR_FUSE
		|| cmd_ff == ppp_pkg::CMD_WR_LOCK || cmd_ff == ppp_pkg::CMD_ERASE;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else if (start && is_write) begin
			busy_ff <= 1'b1;
			cnt_ff <= ppp_pkg::PROG_CYCLES;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 16'h0001;
			if (cnt_ff == 16'h0001)
				busy_ff <= 1'b0;
		end
	end
	assign port.ready_busy = ~busy_ff;
	////////////////////////////////////////////////////////////////////////////
	// Read data select
	logic [7:0] nxt_rd;
	logic [7:0] rd_ff;
	logic oe_ff;
	wire [15:0] fw = flash_mem[addr[ppp_pkg::FLASH_AW-1:0]];
	always_comb begin
		nxt_rd = 8'hFF;
		case (cmd_ff)
			ppp_pkg::CMD_RD_FLASH: nxt_rd = sel1 ? fw[15:8] : fw[7:0];
			ppp_pkg::CMD_RD_EE: nxt_rd = ee_mem[addr[ppp_pkg::EE_AW-1:0]];
			ppp_pkg::CMD_RD_FUSE: nxt_rd = {sel2, sel1} == 2'h0 ? fuse_lo_ff : {sel2, sel1} == 2'h3 ? fuse_hi_ff
				: {sel2, sel1} == 2'h2 ? fuse_ext_ff : lock_ff;
			ppp_pkg::CMD_RD_SIG: nxt_rd = sel1 ? (addr_lo_ff == 8'h00 ? ppp_pkg::CAL_BYTE : 8'hFF)
				: addr_lo_ff == 8'h00 ? ppp_pkg::SIG0 : addr_lo_ff == 8'h01 ? ppp_pkg::SIG1
				: addr_lo_ff == 8'h02 ? ppp_pkg::SIG2 : 8'hFF;
			default: nxt_rd = 8'hFF;
		endcase
	end
	// Drive the bus only while the synchronised output enable is low, three clocks behind the pin
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_ff <= 8'h00;
			oe_ff <= 1'b0;
		end else begin
			rd_ff <= nxt_rd;
			oe_ff <= ~oe_n;
		end
	end
	assign port.data_dev_out = rd_ff;
	assign port.data_dev_oe = oe_ff;
endmodule : ppp_device

// ==== rtl/ppp_host.sv ====
`timescale 1ns/1ps
module ppp_host (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic req, // One-cycle step request
	input wire logic [3:0] op, // Step: 0 load, 1 page latch, 2 write, 3 read
	input wire logic [1:0] act, // Action select for a load
	input wire logic [1:0] sel, // {byte_select_2, byte_select_1}
	input wire logic [7:0] wdata, // Byte to load
	output logic done, // Step finished pulse
	output logic [7:0] rdata, // Read byte
	output logic dev_ready, // Synchronised ready_busy
	ppp_if.host port // Programming pins
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ASSERT = 2'b01, ST_HOLD = 2'b10, ST_WAIT = 2'b11} ppp_st_t;
	ppp_st_t st_ff;
	logic [3:0] cnt_ff;
	logic [3:0] op_ff;
	logic [1:0] act_ff;
	logic [1:0] sel_ff;
	logic [7:0] wd_ff;
	logic rb1_ff;
	logic rb2_ff;
	logic [7:0] d1_ff;
	logic [7:0] d2_ff;
	// Synchronise ready_busy and bus
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rb1_ff <= 1'b1;
			rb2_ff <= 1'b1;
			d1_ff <= 8'h00;
			d2_ff <= 8'h00;
		end else begin
			rb1_ff <= port.ready_busy;
			rb2_ff <= rb1_ff;
			d1_ff <= port.data_bus;
			d2_ff <= d1_ff;
		end
	end
	wire cnt_end = cnt_ff == ppp_pkg::SETUP_CYCLES;
	// Every step waits in WAIT for ready after its fixed strobe and hold phases
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			op_ff <= 4'h0;
			act_ff <= ppp_pkg::ACT_IDLE;
			sel_ff <= 2'h0;
			wd_ff <= 8'h00;
			rdata <= ppp_pkg::NOP_RD;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_ff)
				ST_IDLE: if (req && rb2_ff) begin
					st_ff <= ST_ASSERT;
					op_ff <= op;
					act_ff <= act;
					sel_ff <= sel;
					wd_ff <= wdata;
					cnt_ff <= 4'h0;
				end
				ST_ASSERT: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_end) begin
						st_ff <= ST_HOLD;
						cnt_ff <= 4'h0;
					end
				end
				// Read byte taken once the driven bus has come through the two bus flops
				ST_HOLD: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_end) begin
						st_ff <= ST_WAIT;
						if (op_ff == 4'h3)
							rdata <= d2_ff;
					end
				end
				ST_WAIT: if (rb2_ff) begin
					st_ff <= ST_IDLE;
					done <= 1'b1;
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end
	// Pin drive: selects from ASSERT through WAIT, data too except on reads, strobe in ASSERT
	wire strobe = st_ff == ST_ASSERT;
	wire active = st_ff != ST_IDLE;
	assign port.action_select_hi = active ? act_ff[1] : 1'b1;
	assign port.action_select_lo = active ? act_ff[0] : 1'b1;
	assign port.byte_select_1 = active & sel_ff[0];
	assign port.byte_select_2 = active & sel_ff[1];
	assign port.load_strobe_pin = strobe && op_ff == 4'h0;
	assign port.page_load_strobe = strobe && op_ff == 4'h1;
	assign port.write_strobe_n = ~(strobe && op_ff == 4'h2);
	// Output enable in strobe phase only
	// The device lets go of the bus before the next step can drive it
	assign port.output_enable_n = ~(strobe && op_ff == 4'h3);
	assign port.data_host_out = wd_ff;
	assign port.data_host_oe = active && op_ff != 4'h3;
	assign dev_ready = rb2_ff;
endmodule : ppp_host

// ==== bench/ppp_props.sv ====
`timescale 1ns/1ps
module ppp_props (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic action_select_hi, // Action select high
	input wire logic action_select_lo, // Action select low
	input wire logic byte_select_1, // Byte select one
	input wire logic byte_select_2, // Byte select two
	input wire logic page_load_strobe, // Page latch strobe
	input wire logic load_strobe_pin, // Load strobe
	input wire logic write_strobe_n, // Write strobe, active low
	input wire logic output_enable_n, // Output enable, active low
	input wire logic ready_busy, // High when ready
	input wire logic data_host_oe, // Host drives bus
	input wire logic data_dev_oe // Device drives bus
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	logic [3:0] wr_age_ff;
	logic [3:0] nxt_wr_age;
	// Cycles since the write strobe was last low, saturating
	assign nxt_wr_age = !write_strobe_n ? 4'h0 : ((wr_age_ff == 4'hF) ? 4'hF : wr_age_ff + 4'h1);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			wr_age_ff <= 4'hF;
		else
			wr_age_ff <= nxt_wr_age;
	end
	////////////////////////////////////////////////////////////////////////
	property p_no_clash; !(data_dev_oe && data_host_oe); endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive the bus");
	property p_release; output_enable_n [*6] |-> !data_dev_oe; endproperty
	a_release: assert property (p_release) else $error("device drives bus with output enable high");
	property p_drive; $fell(output_enable_n) |-> ##[1:4] data_dev_oe; endproperty
	a_drive: assert property (p_drive) else $error("device did not drive read data");
	property p_reset_ready; $rose(rst_n) |-> ready_busy; endproperty
	a_reset_ready: assert property (p_reset_ready) else $error("busy after reset");
	property p_busy_cause; $fell(ready_busy) |-> wr_age_ff <= 4'h6; endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write strobe");
	property p_busy_len; $fell(ready_busy) |-> !ready_busy [*8] ##[1:1000] ready_busy; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy period out of bounds");
	property p_wr_ready; $fell(write_strobe_n) |-> ready_busy; endproperty
	a_wr_ready: assert property (p_wr_ready) else $error("write strobe while busy");
	property p_strobe_len; $rose(load_strobe_pin) |-> load_strobe_pin [*4] ##1 !load_strobe_pin; endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("load strobe width wrong");
	property p_sel_hold;
		load_strobe_pin && $past(load_strobe_pin) |->
			$stable({action_select_hi, action_select_lo, byte_select_1, byte_select_2});
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selects moved during load");
	property p_busy_quiet; !ready_busy |-> !load_strobe_pin && !page_load_strobe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while busy");
endmodule : ppp_props

// ==== bench/ppp_tb_top.sv ====
`timescale 1ns/1ps
module ppp_tb_top;
	logic clock, rst_n, req, done, dev_ready;
	logic [3:0] op;
	logic [1:0] act, sel;
	logic [7:0] wdata, rdata;
	int num_errors = 0;
	int tests_run = 0;
	logic busy_seen = 1'b0;
	ppp_if bus ();
	// Notes any busy cycle, so a scenario can tell whether a write strobe started programming
	always @(posedge clock) begin
		if (!bus.ready_busy)
			busy_seen <= 1'b1;
	end
	ppp_device ppp_device_inst (.clock(clock), .rst_n(rst_n), .port(bus.dev));
	ppp_host ppp_host_inst (.clock(clock), .rst_n(rst_n), .req(req), .op(op), .act(act), .sel(sel),
		.wdata(wdata), .done(done), .rdata(rdata), .dev_ready(dev_ready), .port(bus.host));
	ppp_props ppp_props_inst (.clock(clock), .rst_n(rst_n), .action_select_hi(bus.action_select_hi),
		.action_select_lo(bus.action_select_lo), .byte_select_1(bus.byte_select_1),
		.byte_select_2(bus.byte_select_2), .page_load_strobe(bus.page_load_strobe),
		.load_strobe_pin(bus.load_strobe_pin), .write_strobe_n(bus.write_strobe_n),
		.output_enable_n(bus.output_enable_n), .ready_busy(bus.ready_busy),
		.data_host_oe(bus.data_host_oe), .data_dev_oe(bus.data_dev_oe));
	////////////////////////////////////////////////////////////////////////
	// Clock source
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// One host step, then wait for done and for the device to be ready
	task automatic step(input logic [3:0] o, input logic [1:0] a, input logic [1:0] s, input logic [7:0] d);
		int n;
		@(posedge clock);
		req <= 1'b1;
		op <= o;
		act <= a;
		sel <= s;
		wdata <= d;
		@(posedge clock);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (done !== 1'b1 && n < 3000);
		while (dev_ready !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		cmp({7'h00, n >= 3000}, 8'h00);
	endtask : step
	task automatic ld(input logic [1:0] a, input logic [1:0] s, input logic [7:0] d);
		step(4'h0, a, s, d);
	endtask : ld
	task automatic cmd(input logic [7:0] c);
		ld(ppp_pkg::ACT_CMD, 2'h0, c);
	endtask : cmd
	task automatic wr(input logic [1:0] s);
		step(4'h2, ppp_pkg::ACT_IDLE, s, 8'h00);
	endtask : wr
	task automatic rd(input logic [1:0] s, input logic [7:0] exp);
		step(4'h3, ppp_pkg::ACT_IDLE, s, 8'h00);
		cmp(rdata, exp);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	task automatic t_flash;
		cmd(ppp_pkg::CMD_WR_FLASH);
		ld(ppp_pkg::ACT_ADDR, 2'h0, 8'h05);
		ld(ppp_pkg::ACT_DATA, 2'h0, 8'h34);
		ld(ppp_pkg::ACT_DATA, 2'h1, 8'h12);
		step(4'h1, ppp_pkg::ACT_IDLE, 2'h1, 8'h00);
		ld(ppp_pkg::ACT_ADDR, 2'h1, 8'h00);
		busy_seen = 1'b0;
		wr(2'h0);
		cmp({7'h00, busy_seen}, 8'h01);
		cmd(ppp_pkg::CMD_NOP);
		busy_seen = 1'b0;
		wr(2'h0);
		cmp({7'h00, busy_seen}, 8'h00);
		cmd(ppp_pkg::CMD_RD_FLASH);
		ld(ppp_pkg::ACT_ADDR, 2'h1, 8'h00);
		ld(ppp_pkg::ACT_ADDR, 2'h0, 8'h05);
		ld(ppp_pkg::ACT_IDLE, 2'h0, 8'h07);
		rd(2'h0, 8'h34);
		rd(2'h1, 8'h12);
	endtask : t_flash
	task automatic t_eeprom;
		cmd(ppp_pkg::CMD_WR_EE);
		ld(ppp_pkg::ACT_ADDR, 2'h1, 8'h01);
		for (int i = 0; i < 2; i++) begin
			ld(ppp_pkg::ACT_ADDR, 2'h0, 8'(8'h02 + i));
			ld(ppp_pkg::ACT_DATA, 2'h0, 8'(8'hA7 + 8'h11 * i));
			step(4'h1, ppp_pkg::ACT_IDLE, 2'h1, 8'h00);
		end
		wr(2'h0);
		cmd(ppp_pkg::CMD_RD_EE);
		ld(ppp_pkg::ACT_ADDR, 2'h1, 8'h01);
		for (int i = 0; i < 2; i++) begin
			ld(ppp_pkg::ACT_ADDR, 2'h0, 8'(8'h02 + i));
			rd(2'h0, 8'(8'hA7 + 8'h11 * i));
		end
	endtask : t_eeprom
	task automatic t_fuse;
		logic [1:0] ws [3] = '{2'h0, 2'h1, 2'h2};
		logic [1:0] rs [3] = '{2'h0, 2'h3, 2'h2};
		logic [7:0] v [3] = '{8'hE1, 8'h99, 8'hF5};
		for (int i = 0; i < 3; i++) begin
			cmd(ppp_pkg::CMD_WR_FUSE);
			ld(ppp_pkg::ACT_DATA, 2'h0, v[i]);
			wr(ws[i]);
		end
		cmd(ppp_pkg::CMD_RD_FUSE);
		for (int i = 0; i < 3; i++)
			rd(rs[i], v[i]);
		rd(2'h1, ppp_pkg::LOCK_RST);
	endtask : t_fuse
	task automatic t_lock;
		logic [7:0] v [3] = '{8'hFC, 8'hC3, 8'hFF};
		for (int i = 0; i < 3; i++) begin
			cmd(ppp_pkg::CMD_WR_LOCK);
			ld(ppp_pkg::ACT_DATA, 2'h0, v[i]);
			wr(2'h0);
			cmd(ppp_pkg::CMD_RD_FUSE);
			rd(2'h1, 8'hFC);
		end
		cmd(ppp_pkg::CMD_ERASE);
		wr(2'h0);
		cmd(ppp_pkg::CMD_RD_FUSE);
		rd(2'h1, ppp_pkg::LOCK_RST);
		rd(2'h0, 8'hE1);
	endtask : t_lock
	task automatic t_sig;
		logic [7:0] v [3] = '{ppp_pkg::SIG0, ppp_pkg::SIG1, ppp_pkg::SIG2};
		cmd(ppp_pkg::CMD_RD_SIG);
		for (int i = 2; i >= 0; i--) begin
			ld(ppp_pkg::ACT_ADDR, 2'h0, 8'(i));
			rd(2'h0, v[i]);
		end
		rd(2'h1, ppp_pkg::CAL_BYTE);
	endtask : t_sig
	////////////////////////////////////////////////////////////////////////
	// Reset, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		op = 4'h0;
		act = 2'h3;
		sel = 2'h0;
		wdata = 8'h00;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		t_flash();
		t_eeprom();
		t_sig();
		t_fuse();
		t_lock();
		complete_run();
	end
	// Watchdog against a hang
	initial begin
		#(80000 * 25);
		num_errors++;
		complete_run();
	end
endmodule : ppp_tb_top
